// ### shared/hotswap_status_defines.vh
// constants for the hot-swap fault status register bank
// Summary of operation
// RL1: code 0x7b reads output-current byte, resets 0x00
// RL2: bit 7 latches on timed-out overcurrent shutdown
// RL3: bit 5 latches above overcurrent warning threshold
// RL4: current byte bits 6, 4:0 read zero
// RL5: code 0x7c reads input-supply byte, resets 0x00
// RL6: input bit 7 latches on high-limit pin
// RL7: input bit 6 latches above overvoltage warning
// RL8: input bit 5 latches below undervoltage warning
// RL9: input bit 4 latches on low-limit pin
// RL10: input byte bits 3:0 read zero
// RL11: code 0x80 reads vendor byte, resets 0x00
// RL12: vendor bit 7 latches on suspect shorted switch
// RL13: vendor bit 6 follows low-limit comparator live
// RL14: vendor bit 5 follows high-limit comparator live
// RL15: vendor bit 3 latches when current limiting starts
// RL16: vendor bits 2:1 latch shutdown cause code
// RL17: vendor bit 0 latches second warning, selectable polarity
// RL18: vendor bit 4 reads zero
// RL19: summary bit 14 set when current byte nonzero
// RL20: summary bit 13 set when input byte nonzero
// RL21: summary bit 12 set when vendor byte nonzero
// RL22: latched bits hold until clear command or reset
// RL23: host reads each byte singly; writes unsupported
`ifndef HOTSWAP_STATUS_DEFINES_VH
`define HOTSWAP_STATUS_DEFINES_VH

`define CODE_OUTPUT_CURRENT_STATUS  8'h7b
`define CODE_INPUT_SUPPLY_STATUS    8'h7c
`define CODE_VENDOR_SPECIFIC_STATUS 8'h80

`define RESET_OUTPUT_CURRENT_STATUS  8'h00
`define RESET_INPUT_SUPPLY_STATUS    8'h00
`define RESET_VENDOR_SPECIFIC_STATUS 8'h00

// output-current byte
`define BIT_OUTPUT_OVERCURRENT_FAULT   7
`define BIT_OUTPUT_OVERCURRENT_WARNING 5

// input-supply byte
`define BIT_INPUT_OVERVOLTAGE_FAULT    7
`define BIT_INPUT_OVERVOLTAGE_WARNING  6
`define BIT_INPUT_UNDERVOLTAGE_WARNING 5
`define BIT_INPUT_UNDERVOLTAGE_FAULT   4

// vendor-specific byte
`define BIT_SWITCH_SUSPECT_SHORTED     7
`define BIT_LOW_LIMIT_COMPARATOR_LIVE  6
`define BIT_HIGH_LIMIT_COMPARATOR_LIVE 5
`define BIT_CURRENT_LIMITING_ACTIVE    3
`define BIT_SHUTDOWN_REASON_HI         2
`define BIT_SHUTDOWN_REASON_LO         1
`define BIT_SECOND_CURRENT_WARNING     0

`define REASON_NONE         2'h0
`define REASON_OVERCURRENT  2'h1
`define REASON_UNDERVOLTAGE 2'h2
`define REASON_OVERVOLTAGE  2'h3

// summary word flag positions
`define BIT_CURRENT_SUMMARY_FLAG 14
`define BIT_INPUT_SUMMARY_FLAG   13
`define BIT_VENDOR_SUMMARY_FLAG  12

`endif

// ### logic/sticky_flags.v
// group of sticky flags: set wins over clear
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
   parameter WIDTH = 1
) (
   input  wire             clk,   // system clock
   input  wire             rst,   // async reset, high
   input  wire [WIDTH-1:0] set,   // per-flag set pulse or level
   input  wire             clear, // clear all flags
   output reg  [WIDTH-1:0] q      // flag state
);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= {WIDTH{1'b0}};
      end else begin
         // an event in the clearing cycle survives the clear  (see RL22)
         q <= (clear ? {WIDTH{1'b0}} : q) | set;
      end
   end
endmodule
`default_nettype wire

// ### logic/hotswap_fault_status_regs.v
// three latched status bytes of a hot-swap controller, read by command code
`timescale 1ns/1ps
`default_nettype none
`include "hotswap_status_defines.vh"
module hotswap_fault_status_regs #(
   parameter MEAS_W = 12 // monitor sample width
) (
   input  wire              clk,                           // 10 mhz clock
   input  wire              rst,                           // async reset, high
   // command port
   input  wire              cmd_valid,                     // command strobe
   input  wire              cmd_write,                     // 1: write, 0: read byte
   input  wire [7:0]        cmd_code,                      // command code
   output reg  [7:0]        rd_data,                       // read byte
   output reg               rd_valid,                      // read answer pulse
   output reg               cmd_unsupported,               // refused command pulse
   input  wire              clear_faults,                  // fault-clearing command pulse
   // analog protection events
   input  wire              overcurrent_timeout_gate_off,  // timer elapsed, gate shut
   input  wire              current_limiting_active,       // limit loop engaged
   input  wire              switch_suspect_shorted,        // switch health check failed
   input  wire              high_limit_sense_pin,          // high comparator: above threshold
   input  wire              low_limit_sense_pin,           // low comparator: below threshold
   input  wire              switch_enabled,                // gate drive on
   // monitor samples and limits
   input  wire              sample_valid,                  // new samples present
   input  wire [MEAS_W-1:0] iout_sample,                   // output current code
   input  wire [MEAS_W-1:0] vin_sample,                    // input supply code
   input  wire [MEAS_W-1:0] overcurrent_warning_threshold, // current warning limit
   input  wire [MEAS_W-1:0] vin_overvoltage_threshold,     // input high warning limit
   input  wire [MEAS_W-1:0] vin_undervoltage_threshold,    // input low warning limit
   input  wire [MEAS_W-1:0] second_current_threshold,      // second current limit
   input  wire              second_warning_polarity,       // 1: over, 0: under
   // summary flags
   output reg               current_summary_flag,          // current byte nonzero
   output reg               input_summary_flag,            // input byte nonzero
   output reg               vendor_summary_flag            // vendor byte nonzero
);

   // latched event sets
   wire       oc_fault_set;
   wire       oc_warn_set;
   wire       ov_fault_set;
   wire       ov_warn_set;
   wire       uv_warn_set;
   wire       uv_fault_set;
   wire       short_set;
   wire       limit_set;
   wire       warn2_set;
   wire [1:0] cur_q;
   wire [3:0] inp_q;
   wire [2:0] ven_q;

   // comparator copies and shutdown cause
   reg        low_live_q;
   reg        high_live_q;
   reg  [1:0] reason_q;
   reg  [1:0] reason_d;

   // byte images
   reg  [7:0] current_byte;
   reg  [7:0] input_byte;
   reg  [7:0] vendor_byte;
   reg  [7:0] rd_mux;
   reg        code_known;

   assign oc_fault_set = overcurrent_timeout_gate_off;                      // see RL2
   assign oc_warn_set  = sample_valid
                         && (iout_sample > overcurrent_warning_threshold);  // see RL3
   assign ov_fault_set = high_limit_sense_pin;                              // see RL6
   assign ov_warn_set  = sample_valid
                         && (vin_sample > vin_overvoltage_threshold);       // see RL7
   assign uv_warn_set  = sample_valid
                         && (vin_sample < vin_undervoltage_threshold);      // see RL8
   assign uv_fault_set = low_limit_sense_pin;                               // see RL9
   assign short_set    = switch_suspect_shorted;                            // see RL12
   // set at once, no timer involved
   assign limit_set    = current_limiting_active;                           // see RL15
   assign warn2_set    = sample_valid && (second_warning_polarity ?
                         (iout_sample > second_current_threshold) :
                         (iout_sample < second_current_threshold));         // see RL17

   sticky_flags #(
      .WIDTH (2)
   ) current_flags (
      .clk   (clk),
      .rst   (rst),
      .set   ({oc_fault_set, oc_warn_set}),
      .clear (clear_faults),
      .q     (cur_q)
   );

   sticky_flags #(
      .WIDTH (4)
   ) input_flags (
      .clk   (clk),
      .rst   (rst),
      .set   ({ov_fault_set, ov_warn_set, uv_warn_set, uv_fault_set}),
      .clear (clear_faults),
      .q     (inp_q)
   );

   sticky_flags #(
      .WIDTH (3)
   ) vendor_flags (
      .clk   (clk),
      .rst   (rst),
      .set   ({short_set, limit_set, warn2_set}),
      .clear (clear_faults),
      .q     (ven_q)
   );

   // comparator bits are live, one register stage behind the pins
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         low_live_q  <= 1'b0;
         high_live_q <= 1'b0;
      end else begin
         low_live_q  <= low_limit_sense_pin;  // see RL13
         high_live_q <= high_limit_sense_pin; // see RL14
      end
   end

   // first cause sticks; a simultaneous pair resolves ov, then uv, then oc
   always @* begin
      reason_d = clear_faults ? `REASON_NONE : reason_q;
      if (reason_d == `REASON_NONE) begin
         if (switch_enabled && high_limit_sense_pin) begin
            reason_d = `REASON_OVERVOLTAGE;               // see RL16
         end else if (switch_enabled && low_limit_sense_pin) begin
            reason_d = `REASON_UNDERVOLTAGE;              // see RL16
         end else if (overcurrent_timeout_gate_off) begin
            reason_d = `REASON_OVERCURRENT;               // see RL16
         end
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         reason_q <= `REASON_NONE;
      end else begin
         reason_q <= reason_d; // see RL22
      end
   end

   always @* begin
      current_byte = `RESET_OUTPUT_CURRENT_STATUS;                    // see RL4
      current_byte[`BIT_OUTPUT_OVERCURRENT_FAULT]   = cur_q[1];
      current_byte[`BIT_OUTPUT_OVERCURRENT_WARNING] = cur_q[0];
      input_byte = `RESET_INPUT_SUPPLY_STATUS;                        // see RL10
      input_byte[`BIT_INPUT_OVERVOLTAGE_FAULT]    = inp_q[3];
      input_byte[`BIT_INPUT_OVERVOLTAGE_WARNING]  = inp_q[2];
      input_byte[`BIT_INPUT_UNDERVOLTAGE_WARNING] = inp_q[1];
      input_byte[`BIT_INPUT_UNDERVOLTAGE_FAULT]   = inp_q[0];
      vendor_byte = `RESET_VENDOR_SPECIFIC_STATUS;                    // see RL18
      vendor_byte[`BIT_SWITCH_SUSPECT_SHORTED]     = ven_q[2];
      vendor_byte[`BIT_LOW_LIMIT_COMPARATOR_LIVE]  = low_live_q;
      vendor_byte[`BIT_HIGH_LIMIT_COMPARATOR_LIVE] = high_live_q;
      vendor_byte[`BIT_CURRENT_LIMITING_ACTIVE]    = ven_q[1];
      vendor_byte[`BIT_SHUTDOWN_REASON_HI]         = reason_q[1];
      vendor_byte[`BIT_SHUTDOWN_REASON_LO]         = reason_q[0];
      vendor_byte[`BIT_SECOND_CURRENT_WARNING]     = ven_q[0];
   end

   // read-byte decode
   always @* begin
      rd_mux     = 8'h00;
      code_known = 1'b1;
      case (cmd_code)
         `CODE_OUTPUT_CURRENT_STATUS:  rd_mux = current_byte; // see RL1
         `CODE_INPUT_SUPPLY_STATUS:    rd_mux = input_byte;   // see RL5
         `CODE_VENDOR_SPECIFIC_STATUS: rd_mux = vendor_byte;  // see RL11
         default:                      code_known = 1'b0;
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data         <= 8'h00;
         rd_valid        <= 1'b0;
         cmd_unsupported <= 1'b0;
      end else begin
         rd_valid        <= cmd_valid && !cmd_write && code_known;
         // writes to read-only status codes are refused  (see RL23)
         cmd_unsupported <= cmd_valid && (cmd_write || !code_known);
         if (cmd_valid && !cmd_write && code_known) begin
            rd_data <= rd_mux;
         end
      end
   end

   // summary flags track the bytes with the same one-cycle register stage
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         current_summary_flag <= 1'b0;
         input_summary_flag   <= 1'b0;
         vendor_summary_flag  <= 1'b0;
      end else begin
         current_summary_flag <= |current_byte; // see RL19
         input_summary_flag   <= |input_byte;   // see RL20
         vendor_summary_flag  <= |vendor_byte;  // see RL21
      end
   end

endmodule
`default_nettype wire

// ### bench/hotswap_host_model.sv
// host model issuing single-byte status command transfers
`timescale 1ns/1ps
`default_nettype none
module hotswap_host_model (
   input  wire logic       clk,            // clock
   output var  logic       cmd_valid,      // command strobe
   output var  logic       cmd_write,      // write select
   output var  logic [7:0] cmd_code,       // command code
   input  wire logic [7:0] rd_data,        // read byte
   input  wire logic       rd_valid,       // read answer
   input  wire logic       cmd_unsupported // refusal answer
);
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code = 8'h00;
   end
   // one command carries one byte, no framing beyond that
   task automatic xfer(input logic w, input logic [7:0] c, output logic [7:0] d,
                       output logic [1:0] k, output logic to);
      int n;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_code <= c;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_write <= ~w; // idle lines show junk, not the old request
      cmd_code <= ~c;
      k = 2'b00;
      for (n = 0; n < 4 && k == 2'b00; n++) begin
         @(negedge clk);
         k = {cmd_unsupported, rd_valid};
      end
      d = rd_data;
      to = (k == 2'b00);
   endtask
endmodule
`default_nettype wire

// ### bench/hotswap_fault_status_regs_chk.sv
// assertion checker on the status register bank ports
`timescale 1ns/1ps
`default_nettype none
module hotswap_status_chk (
   input wire logic       clk,                          // clock
   input wire logic       rst,                          // async reset
   input wire logic       cmd_valid,                    // strobe
   input wire logic       cmd_write,                    // write select
   input wire logic [7:0] cmd_code,                     // code
   input wire logic [7:0] rd_data,                      // read byte
   input wire logic       rd_valid,                     // answer
   input wire logic       cmd_unsupported,              // refusal
   input wire logic       clear_faults,                 // clear
   input wire logic       overcurrent_timeout_gate_off, // oc fault
   input wire logic       current_limiting_active,      // limiting
   input wire logic       high_limit_sense_pin,         // high pin
   input wire logic       low_limit_sense_pin,          // low pin
   input wire logic       current_summary_flag,         // flag 14
   input wire logic       input_summary_flag,           // flag 13
   input wire logic       vendor_summary_flag           // flag 12
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire known = cmd_code == 8'h7b || cmd_code == 8'h7c || cmd_code == 8'h80;
   sequence s_read;
      cmd_valid && !cmd_write && known;
   endsequence
   sequence s_answer(logic [7:0] c);
      rd_valid && $past(cmd_code) == c;
   endsequence
   AST_READ_OK: assert property (s_read |=> rd_valid && !cmd_unsupported) else $error("read not answered");
   AST_REFUSE: assert property (cmd_valid && !(known && !cmd_write) |=> cmd_unsupported && !rd_valid && $stable(rd_data)) else $error("bad command not refused");
   AST_IDLE: assert property (!cmd_valid |=> !rd_valid && !cmd_unsupported) else $error("answer without command");
   AST_CUR_ZERO: assert property (s_answer(8'h7b) |-> (rd_data & 8'h5f) == 8'h00) else $error("current byte unused bits set");
   AST_IN_ZERO: assert property (s_answer(8'h7c) |-> rd_data[3:0] == 4'h0) else $error("input byte unused bits set");
   AST_VEN_ZERO: assert property (s_answer(8'h80) |-> !rd_data[4]) else $error("vendor bit 4 set");
   AST_LIVE: assert property (s_answer(8'h80) |-> rd_data[6:5] == {$past(low_limit_sense_pin, 2), $past(high_limit_sense_pin, 2)}) else $error("live bits wrong");
   AST_OV_SUM: assert property (high_limit_sense_pin ##1 !clear_faults |=> input_summary_flag) else $error("input flag missing");
   AST_OC_SUM: assert property (overcurrent_timeout_gate_off ##1 !clear_faults |=> current_summary_flag) else $error("current flag missing");
   AST_LIM_SUM: assert property (current_limiting_active ##1 !clear_faults |=> vendor_summary_flag) else $error("vendor flag missing");
   AST_HOLD: assert property (input_summary_flag && !$past(clear_faults) |=> input_summary_flag) else $error("latched bit lost");
endmodule
bind hotswap_fault_status_regs hotswap_status_chk i_hotswap_status_chk (.clk, .rst, .cmd_valid,
   .cmd_write, .cmd_code, .rd_data, .rd_valid, .cmd_unsupported, .clear_faults,
   .overcurrent_timeout_gate_off, .current_limiting_active, .high_limit_sense_pin,
   .low_limit_sense_pin, .current_summary_flag, .input_summary_flag, .vendor_summary_flag);
`default_nettype wire

// ### bench/test_hotswap_fault_status_regs.sv
// self-checking bench for the status register bank
`timescale 1ns/1ps
`default_nettype none
module test_hotswap_fault_status_regs;
   logic        clk = 1'b0, rst = 1'b1, clr = 1'b0, sv = 1'b0, pol = 1'b0, to;
   logic        cv, cw, rv, cu, fc, fi, fv, en = 1'b1;
   logic [7:0]  code, rdat, got;
   logic [1:0]  k;
   logic [4:0]  ev = 5'h00;
   logic [11:0] iout = 12'h000, vin = 12'h000, oc = 12'h000, ov = 12'h000, uv = 12'h000;
   logic [11:0] t2 = 12'h000, r, d;
   int          num_errors = 0, checks = 0;
   always #50 clk = ~clk;
   hotswap_fault_status_regs i_hotswap_fault_status_regs (.clk(clk), .rst(rst), .cmd_valid(cv),
      .cmd_write(cw), .cmd_code(code), .rd_data(rdat), .rd_valid(rv), .cmd_unsupported(cu),
      .clear_faults(clr), .overcurrent_timeout_gate_off(ev[0]), .current_limiting_active(ev[1]),
      .switch_suspect_shorted(ev[2]), .high_limit_sense_pin(ev[3]), .low_limit_sense_pin(ev[4]),
      .switch_enabled(en), .sample_valid(sv), .iout_sample(iout), .vin_sample(vin),
      .overcurrent_warning_threshold(oc), .vin_overvoltage_threshold(ov),
      .vin_undervoltage_threshold(uv), .second_current_threshold(t2),
      .second_warning_polarity(pol), .current_summary_flag(fc), .input_summary_flag(fi),
      .vendor_summary_flag(fv));
   hotswap_host_model i_hotswap_host_model (.clk(clk), .cmd_valid(cv), .cmd_write(cw),
      .cmd_code(code), .rd_data(rdat), .rd_valid(rv), .cmd_unsupported(cu));
   task summarize();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(string n, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // {current, input, vendor} bytes per event; live adds comparator bits
   function logic [23:0] expv(int i, bit live);
      case (i)
         0: return 24'h800002;
         1: return 24'h000008;
         2: return 24'h000080;
         3: return live ? 24'h008026 : 24'h008006;
         4: return live ? 24'h001044 : 24'h001004;
         5: return 24'h200000;
         6: return 24'h004000;
         7: return 24'h002000;
         default: return 24'h000001;
      endcase
   endfunction
   task xf(logic w, logic [7:0] c, logic [1:0] ek, logic [7:0] e);
      i_hotswap_host_model.xfer(w, c, got, k, to);
      if (to) begin
         num_errors++;
         summarize();
      end else begin
         chk("answer kind", {6'h00, ek}, {6'h00, k});
         chk($sformatf("byte %h", c), e, got);
      end
   endtask
   task rd3(logic [23:0] e);
      xf(1'b0, 8'h7b, 2'b01, e[23:16]);
      xf(1'b0, 8'h7c, 2'b01, e[15:8]);
      xf(1'b0, 8'h80, 2'b01, e[7:0]);
      chk("summary", {5'h00, |e[23:16], |e[15:8], |e[7:0]}, {5'h00, fc, fi, fv});
   endtask
   // strict compares: value equal to its threshold never trips
   task drive(int i, bit on);
      r = $urandom_range(3000, 1000);
      d = $urandom_range(50, 1);
      ev <= (on && i < 5) ? 5'h01 << i : 5'h00;
      sv <= on && i > 4;
      iout <= (i == 5 || i == 8) ? r + d : (i == 9 ? r - d : r);
      vin <= i == 6 ? r + d : (i == 7 ? r - d : r);
      oc <= i == 5 ? r : r + 12'h400;
      ov <= r;
      uv <= r;
      t2 <= r;
      pol <= i != 5 && i != 9;
   endtask
   initial begin
      void'($urandom(32'hc25e64cf));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd3(24'h000000);
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         drive(i, 1'b1);
         repeat (2) @(posedge clk);
         rd3(expv(i, 1'b1));
         @(posedge clk);
         drive(i, 1'b0);
         repeat (3) @(posedge clk);
         rd3(expv(i, 1'b0));
         xf(1'b1, i % 2 ? 8'h7c : 8'h80, 2'b10, 8'(expv(i, 1'b0)));
         xf(1'b0, 8'(8'h81 + i), 2'b10, 8'(expv(i, 1'b0)));
         @(posedge clk);
         clr <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         repeat (3) @(posedge clk);
         rd3(24'h000000);
      end
      // gate off: no shutdown cause; event in the clearing cycle must survive
      @(posedge clk);
      en <= 1'b0;
      clr <= 1'b1;
      drive(4, 1'b1);
      @(posedge clk);
      clr <= 1'b0;
      repeat (2) @(posedge clk);
      rd3(24'h001040);
      @(posedge clk);
      drive(4, 1'b0);
      repeat (3) @(posedge clk);
      rd3(24'h001000);
      // a mid-run reset wipes every latched bit
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      en <= 1'b1;
      repeat (2) @(posedge clk);
      rd3(24'h000000);
      summarize();
   end
endmodule
`default_nettype wire
